// >>> logic/cgmc_map.vh
// Register map, field positions, reset values and timing of the clock config
`ifndef CGMC_MAP_VH
`define CGMC_MAP_VH

`define CGMC_ADDR_W          5
`define CGMC_OFS_CTRL_ONE    5'h00
`define CGMC_OFS_CTRL_TWO    5'h04
`define CGMC_OFS_STAT_ONE    5'h08
`define CGMC_OFS_STAT_TWO    5'h0c
`define CGMC_OFS_FILTER      5'h10
`define CGMC_OFS_TRIM        5'h14

`define CGMC_C1_GAIN         7
`define CGMC_C1_RANGE        6
`define CGMC_C1_REFSEL       5
`define CGMC_C1_MODE_HI      4
`define CGMC_C1_MODE_LO      3
`define CGMC_C1_STOPOSC      2
`define CGMC_C1_LOCDIS       1
`define CGMC_C1_WMASK        8'hfe

`define CGMC_C2_LOLRST       7
`define CGMC_C2_MULT_HI      6
`define CGMC_C2_MULT_LO      4
`define CGMC_C2_LOCRST       3
`define CGMC_C2_DIV_HI       2
`define CGMC_C2_DIV_LO       0

`define CGMC_S1_MODE_HI      7
`define CGMC_S1_MODE_LO      6
`define CGMC_S1_REFOK        5
`define CGMC_S1_LOCLOST      4
`define CGMC_S1_LOCKED       3
`define CGMC_S1_LOLLOST      2
`define CGMC_S1_IRQ          0
`define CGMC_S2_OSCSTABLE    0

`define CGMC_MODE_SCM        2'b00
`define CGMC_MODE_FEI        2'b01
`define CGMC_MODE_FBE        2'b10
`define CGMC_MODE_FEE        2'b11

`define CGMC_CTRL_ONE_RST    8'h00
`define CGMC_CTRL_TWO_RST    8'h00
`define CGMC_FILTER_W        12
`define CGMC_FILTER_RST      12'h800
`define CGMC_TRIM_RST        8'h80

`define CGMC_SCM_OUT_KHZ     8000
`define CGMC_SCM_BUS_KHZ     4000
`define CGMC_IRG_KHZ         243
`define CGMC_IRG_DIV         7
`define CGMC_PRESCALE_LOW    7'h40
`define CGMC_PRESCALE_HIGH   7'h01

`define CGMC_CLK_PERIOD_NS   4
`define CGMC_MODE_SETTLE_NS  16
// Settle span in clocks: 16 ns at a 4 ns period
`define CGMC_MODE_SETTLE_CYC 3'h4

`endif

// >>> logic/cgmc_sync.v
// Three-stage synchroniser for inputs from the analog side
`timescale 1ns/10ps
module cgmc_sync (
  input  wire clk_sys,
  input  wire reset_n,
  input  wire asyncIn,
  output reg  syncOut
);
  reg stageOne;
  reg stageTwo;
  reg stageThree;

  // Output only moves once the last two stages agree
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stageOne   <= 1'b0;
      stageTwo   <= 1'b0;
      stageThree <= 1'b0;
      syncOut    <= 1'b0;
    end else begin
      stageOne   <= asyncIn;
      stageTwo   <= stageOne;
      stageThree <= stageTwo;
      if (stageTwo == stageThree)
        syncOut <= stageThree;
    end
  end
endmodule

// >>> logic/cgmc_factor_decode.v
// Decode of prescale, multiply and divide factors
`timescale 1ns/10ps
`include "cgmc_map.vh"
module cgmc_factor_decode (
  input  wire       rangeHigh,
  input  wire [2:0] multiplySelect,
  input  wire [2:0] divideSelect,
  output wire [6:0] prescale,
  output wire [4:0] multiply,
  output wire [7:0] divide
);
  assign prescale = rangeHigh ? `CGMC_PRESCALE_HIGH
                              : `CGMC_PRESCALE_LOW;
  // 000 -> 4, 011 -> 10: N = 2*code + 4
  assign multiply = {1'b0, multiplySelect, 1'b0} + 5'h04;
  // 000 -> 1, 001 -> 2: R = 2^code
  assign divide = 8'h01 << divideSelect;
endmodule

// >>> logic/cgmc_clock_config.v
// Mode control and configuration registers of the clock generator
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "cgmc_map.vh"
module cgmc_clock_config (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [4:0]  address,
  input  wire [3:0]  byteenable,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire        loopLockedPin,
  input  wire        refClockOkPin,
  input  wire        oscStablePin,
  input  wire        loopFilterStrobe,
  input  wire [11:0] loopFilterNext,
  output wire        irqRequest,
  output reg         resetRequest,
  output wire        oscRequest,
  output wire        highGain,
  output wire        rangeHigh,
  output wire        stopOscEnable,
  output wire        clockDetectEnable,
  output wire        loopEngaged,
  output wire        externalReference,
  output wire        refDivideSeven,
  output wire [6:0]  prescaleFactor,
  output wire [4:0]  multiplyFactor,
  output wire [7:0]  divideFactor,
  output wire [11:0] dcoFilter,
  output wire [7:0]  refTrim
);
  localparam [3:0] ST_SCM = 4'b0001;
  localparam [3:0] ST_FEI = 4'b0010;
  localparam [3:0] ST_FBE = 4'b0100;
  localparam [3:0] ST_FEE = 4'b1000;
  localparam [2:0] SETTLE_CYC = `CGMC_MODE_SETTLE_CYC;

  reg  [7:0]  ctrlOne;
  reg  [7:0]  ctrlTwo;
  reg  [11:0] filter;
  reg  [7:0]  trim;
  reg         gainWritten;
  reg         irqFlag;
  reg         lockLostFlag;
  reg         clockLostFlag;
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [2:0]  settleCount;
  reg  [1:0]  targetMode;
  reg         ack;
  reg         lockedPrev;
  reg         refOkPrev;
  wire        locked;
  wire        refOk;
  wire        oscStable;

  cgmc_sync lockSync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .asyncIn (loopLockedPin),
    .syncOut (locked)
  );
  cgmc_sync refSync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .asyncIn (refClockOkPin),
    .syncOut (refOk)
  );
  cgmc_sync stableSync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .asyncIn (oscStablePin),
    .syncOut (oscStable)
  );

  // One wait state on every access, so decode is settled before the answer
  wire request = read | write;
  assign waitrequest = request & ~ack;
  wire takeWrite = write & ack;
  // Read data loads in the waiting cycle so it stands at the answering edge
  wire loadRead  = read & ~ack;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      ack <= 1'b0;
    else
      ack <= request & ~ack;
  end

  wire hitOne   = (address == `CGMC_OFS_CTRL_ONE);
  wire hitTwo   = (address == `CGMC_OFS_CTRL_TWO);
  wire hitStat1 = (address == `CGMC_OFS_STAT_ONE);
  wire hitStat2 = (address == `CGMC_OFS_STAT_TWO);
  wire hitFilt  = (address == `CGMC_OFS_FILTER);
  wire hitTrim  = (address == `CGMC_OFS_TRIM);

  wire [1:0] modeSelect = ctrlOne[`CGMC_C1_MODE_HI:`CGMC_C1_MODE_LO];
  wire inScm = state[0];
  wire inFei = state[1];
  wire inFee = state[3];
  wire inExternal = state[2] | state[3];

  // Loss events, seen only while the matching path is in use
  wire lockLossEvent  = (inFei | inFee) & lockedPrev & ~locked;
  wire clockLossEvent = inExternal & refOkPrev & ~refOk &
                        ~ctrlOne[`CGMC_C1_LOCDIS];
  wire lockToIrq  = lockLossEvent & ~ctrlTwo[`CGMC_C2_LOLRST];
  wire clockToIrq = clockLossEvent & ~ctrlTwo[`CGMC_C2_LOCRST];
  wire lockToRst  = lockLossEvent & ctrlTwo[`CGMC_C2_LOLRST];
  wire clockToRst = clockLossEvent & ctrlTwo[`CGMC_C2_LOCRST];
  wire irqClear = takeWrite & hitStat1 & byteenable[0] &
                  writedata[`CGMC_S1_IRQ];

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrlOne     <= `CGMC_CTRL_ONE_RST;
      ctrlTwo     <= `CGMC_CTRL_TWO_RST;
      gainWritten <= 1'b0;
      trim        <= `CGMC_TRIM_RST;
    end else if (takeWrite && byteenable[0]) begin
      if (hitOne) begin
        // Gain bit locks after its first write
        ctrlOne[6:1] <= writedata[6:1];
        if (!gainWritten) begin
          ctrlOne[`CGMC_C1_GAIN] <= writedata[`CGMC_C1_GAIN];
          gainWritten <= 1'b1;
        end
      end
      if (hitTwo)
        ctrlTwo <= writedata[7:0];
      if (hitTrim)
        trim <= writedata[7:0];
    end
  end

  // Software may load the filter only self-clocked; the loop owns it otherwise
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      filter <= `CGMC_FILTER_RST;
    else if (inScm && takeWrite && hitFilt) begin
      if (byteenable[0])
        filter[7:0] <= writedata[7:0];
      if (byteenable[1])
        filter[11:8] <= writedata[11:8];
    end else if (!inScm && loopFilterStrobe)
      filter <= loopFilterNext;
  end

  // Set wins over the software clear
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqFlag       <= 1'b0;
      lockLostFlag  <= 1'b0;
      clockLostFlag <= 1'b0;
      resetRequest  <= 1'b0;
      lockedPrev    <= 1'b0;
      refOkPrev     <= 1'b0;
    end else begin
      lockedPrev   <= locked;
      refOkPrev    <= refOk;
      resetRequest <= lockToRst | clockToRst;
      if (lockToIrq | clockToIrq)
        irqFlag <= 1'b1;
      else if (irqClear)
        irqFlag <= 1'b0;
      if (lockLossEvent)
        lockLostFlag <= 1'b1;
      else if (irqClear)
        lockLostFlag <= 1'b0;
      if (clockLossEvent)
        clockLostFlag <= 1'b1;
      else if (irqClear)
        clockLostFlag <= 1'b0;
    end
  end

  // Mode follows the select after a short settle, so status lags the write
  always @* begin
    next_state = state;
    if (clockLossEvent)
      next_state = ST_SCM;
    else if (settleCount == SETTLE_CYC) begin
      case (targetMode)
        `CGMC_MODE_FEE: next_state = refOk ? ST_FEE : ST_SCM;
        `CGMC_MODE_FEI: next_state = ST_FEI;
        `CGMC_MODE_FBE: next_state = refOk ? ST_FBE : ST_SCM;
        default:        next_state = ST_SCM;
      endcase
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_SCM;
      targetMode  <= `CGMC_MODE_SCM;
      settleCount <= 3'h0;
    end else begin
      state <= next_state;
      if (modeSelect != targetMode) begin
        targetMode  <= modeSelect;
        settleCount <= 3'h0;
      end else if (settleCount != SETTLE_CYC)
        settleCount <= settleCount + 3'h1;
    end
  end

  reg [1:0] modeStatus;
  always @* begin
    case (state)
      ST_FEI:  modeStatus = `CGMC_MODE_FEI;
      ST_FBE:  modeStatus = `CGMC_MODE_FBE;
      ST_FEE:  modeStatus = `CGMC_MODE_FEE;
      default: modeStatus = `CGMC_MODE_SCM;
    endcase
  end

  wire [7:0] statusOne = {modeStatus, refOk, clockLostFlag,
                          locked, lockLostFlag, 1'b0, irqFlag};

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      readdata <= 32'h00000000;
    else if (loadRead) begin
      if (hitOne)
        readdata <= {24'h000000, ctrlOne & `CGMC_C1_WMASK |
                     {ctrlOne[`CGMC_C1_GAIN], 7'h00}};
      else if (hitTwo)
        readdata <= {24'h000000, ctrlTwo};
      else if (hitStat1)
        readdata <= {24'h000000, statusOne};
      else if (hitStat2)
        readdata <= {31'h00000000, oscStable};
      else if (hitFilt)
        readdata <= {20'h00000, filter};
      else if (hitTrim)
        readdata <= {24'h000000, trim};
      else
        readdata <= 32'h00000000;
    end
  end

  cgmc_factor_decode factors (
    .rangeHigh      (ctrlOne[`CGMC_C1_RANGE]),
    .multiplySelect (ctrlTwo[`CGMC_C2_MULT_HI:`CGMC_C2_MULT_LO]),
    .divideSelect   (ctrlTwo[`CGMC_C2_DIV_HI:`CGMC_C2_DIV_LO]),
    .prescale       (prescaleFactor),
    .multiply       (multiplyFactor),
    .divide         (divideFactor)
  );

  // Loop target: ref * P * N / R, internal ref first divided by 7
  assign loopEngaged       = inFei | inFee;
  assign externalReference = inExternal;
  assign refDivideSeven    = inFei;
  // Internal mode never needs the crystal
  assign oscRequest = ctrlOne[`CGMC_C1_REFSEL] &
                      (modeSelect != `CGMC_MODE_FEI);
  assign highGain          = ctrlOne[`CGMC_C1_GAIN];
  assign rangeHigh         = ctrlOne[`CGMC_C1_RANGE];
  assign stopOscEnable     = ctrlOne[`CGMC_C1_STOPOSC];
  assign clockDetectEnable = ~ctrlOne[`CGMC_C1_LOCDIS];
  assign irqRequest        = irqFlag;
  assign dcoFilter         = filter;
  assign refTrim           = trim;
endmodule

// >>> dv/cgmc_clock_config_assertions.sv
// Port-level checks of the clock configuration block
`timescale 1ns/10ps
module cgmc_checker (
  input logic        clk_sys,
  input logic        reset_n,
  input logic        read,
  input logic        write,
  input logic        waitrequest,
  input logic        loopLockedPin,
  input logic        refClockOkPin,
  input logic        loopFilterStrobe,
  input logic [11:0] loopFilterNext,
  input logic        irqRequest,
  input logic        resetRequest,
  input logic        clockDetectEnable,
  input logic        loopEngaged,
  input logic        externalReference,
  input logic        refDivideSeven,
  input logic        rangeHigh,
  input logic [6:0]  prescaleFactor,
  input logic [4:0]  multiplyFactor,
  input logic [7:0]  divideFactor,
  input logic [11:0] dcoFilter
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  start_self_clock_a: assert property ($rose(reset_n) |->
    !loopEngaged && !externalReference) else $error("not self-clocked");
  prescale_pick_a: assert property (prescaleFactor ==
    (rangeHigh ? 7'h01 : 7'h40)) else $error("bad prescale");
  multiply_code_a: assert property (!multiplyFactor[0] &&
    multiplyFactor >= 5'd4 && multiplyFactor <= 5'd18) else $error("bad N");
  divide_power_a: assert property ($onehot(divideFactor))
    else $error("bad R");
  seven_div_a: assert property (refDivideSeven ==
    (loopEngaged && !externalReference)) else $error("bad ref divide");
  reset_pulse_a: assert property (resetRequest |=> !resetRequest)
    else $error("reset request too long");
  lock_loss_a: assert property (loopEngaged && $fell(loopLockedPin) &&
    $past(loopLockedPin, 4) |-> ##[1:8] (irqRequest || resetRequest))
    else $error("lock loss unseen");
  clock_loss_a: assert property (externalReference &&
    clockDetectEnable && $fell(refClockOkPin) && $past(refClockOkPin, 4)
    |-> ##[1:8] (irqRequest || resetRequest) ##[0:8] !externalReference)
    else $error("clock loss unseen");
  irq_sticky_a: assert property (irqRequest && !write |=> irqRequest)
    else $error("irq dropped alone");
  filter_track_a: assert property (loopEngaged && loopFilterStrobe
    |=> dcoFilter == $past(loopFilterNext)) else $error("filter stale");
  bus_answer_a: assert property ((read || write) |-> ##[0:1] !waitrequest)
    else $error("no answer");
  cover property ($rose(irqRequest));
  cover property ($rose(resetRequest));
  cover property ($rose(loopEngaged && externalReference));
endmodule
bind cgmc_clock_config cgmc_checker chk (.clk_sys, .reset_n, .read,
  .write, .waitrequest, .loopLockedPin, .refClockOkPin, .loopFilterStrobe,
  .loopFilterNext, .irqRequest, .resetRequest, .clockDetectEnable,
  .loopEngaged, .externalReference, .refDivideSeven, .rangeHigh,
  .prescaleFactor, .multiplyFactor, .divideFactor, .dcoFilter);

// >>> dv/cgmc_ref_source.sv
// External reference source and analog loop side
`timescale 1ns/10ps
module cgmc_ref_source (
  input  logic        clk_sys,
  input  logic        reset_n,
  input  logic        oscRequest,
  input  logic        loopEngaged,
  input  logic        refPresent,
  input  logic        lockEnable,
  input  logic        slowStart,
  output logic        loopLockedPin,
  output logic        refClockOkPin,
  output logic        oscStablePin,
  output logic        loopFilterStrobe,
  output logic [11:0] loopFilterNext
);
  int startCnt;
  int lockCnt;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      startCnt <= 0;
      lockCnt <= 0;
      oscStablePin <= 1'b0;
      loopLockedPin <= 1'b0;
      refClockOkPin <= 1'b0;
      loopFilterStrobe <= 1'b0;
      loopFilterNext <= 12'h000;
    end else begin
      // Clock source runs whether requested or not
      refClockOkPin <= refPresent;
      // Crystal starts only when requested
      startCnt <= oscRequest ? startCnt + 1 : 0;
      oscStablePin <= oscRequest && startCnt >= (slowStart ? 40 : 4);
      lockCnt <= (loopEngaged && lockEnable) ? lockCnt + 1 : 0;
      loopLockedPin <= lockCnt >= 16;
      loopFilterStrobe <= lockCnt > 16 && lockCnt[2:0] == 3'h0;
      // Changes every cycle so a stale capture shows
      loopFilterNext <= loopFilterNext + 12'h013;
    end
  end
endmodule

// >>> dv/tb_top.sv
// Register-level bench of the clock configuration block
`timescale 1ns/10ps
`include "cgmc_map.vh"
`define CHECK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clk_sys, reset_n, read, write, waitrequest;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata;
  logic lockPin, refOkPin, stablePin, strobe, irqRequest, resetRequest;
  logic oscRequest, highGain, rangeHigh, stopOscEnable, clockDetectEnable;
  logic loopEngaged, externalReference, refDivideSeven;
  logic refPresent, lockEnable, slowStart;
  logic [11:0] filterNext, dcoFilter, prior;
  logic [6:0]  prescaleFactor;
  logic [4:0]  multiplyFactor;
  logic [7:0]  divideFactor, refTrim;
  int fails = 0, testsRun = 0, resetSeen = 0, prev;
  cgmc_clock_config dut (.clk_sys, .reset_n, .address, .byteenable, .read,
    .write, .writedata, .readdata, .waitrequest, .loopLockedPin(lockPin),
    .refClockOkPin(refOkPin), .oscStablePin(stablePin),
    .loopFilterStrobe(strobe), .loopFilterNext(filterNext), .irqRequest,
    .resetRequest, .oscRequest, .highGain, .rangeHigh, .stopOscEnable,
    .clockDetectEnable, .loopEngaged, .externalReference, .refDivideSeven,
    .prescaleFactor, .multiplyFactor, .divideFactor, .dcoFilter, .refTrim);
  cgmc_ref_source src (.clk_sys, .reset_n, .oscRequest, .loopEngaged,
    .refPresent, .lockEnable, .slowStart, .loopLockedPin(lockPin),
    .refClockOkPin(refOkPin), .oscStablePin(stablePin),
    .loopFilterStrobe(strobe), .loopFilterNext(filterNext));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (resetRequest === 1'b1) resetSeen++;
  task automatic results();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic doReset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  // Read data is taken at the edge where waitrequest is sampled low
  task automatic access(input logic w, input logic [4:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    n = 0;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50) fails++;
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  // Polls until the masked value shows, bounded
  task automatic poll(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm);
    logic [31:0] q;
    for (int n = 0; n < 60; n++) begin
      access(1'b0, a, 32'h0, q);
      if ((q & m) === e) break;
    end
    `CHECK(nm, e, q & m)
  endtask
  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    refPresent = 1'b1;
    lockEnable = 1'b0;
    slowStart = 1'b0;
    doReset();
    poll(`CGMC_OFS_CTRL_ONE, 32'hff, 32'h00, "ctrl one");
    poll(`CGMC_OFS_FILTER, 32'hffff, 32'h0800, "filter");
    poll(`CGMC_OFS_TRIM, 32'hff, 32'h80, "trim");
    poll(`CGMC_OFS_STAT_ONE, 32'hc0, 32'h00, "mode");
    wr(5'h18, 32'hff);
    poll(5'h18, 32'hffffffff, 32'h0, "unmapped");
    wr(`CGMC_OFS_CTRL_ONE, 32'hc7);
    poll(`CGMC_OFS_CTRL_ONE, 32'hff, 32'hc6, "ctrl one");
    `CHECK("gain", 1'b1, highGain)
    `CHECK("detect", 1'b0, clockDetectEnable)
    `CHECK("stop osc", 1'b1, stopOscEnable)
    `CHECK("prescale", 7'h01, prescaleFactor)
    wr(`CGMC_OFS_CTRL_ONE, 32'h00);
    poll(`CGMC_OFS_CTRL_ONE, 32'hff, 32'h80, "gain once");
    `CHECK("prescale", 7'h40, prescaleFactor)
    wr(`CGMC_OFS_FILTER, 32'h0000abcd);
    poll(`CGMC_OFS_FILTER, 32'hffff, 32'h0bcd, "filter");
    `CHECK("filter out", 12'hbcd, dcoFilter)
    for (int i = 0; i < 8; i++) begin
      wr(`CGMC_OFS_CTRL_TWO, {24'h0, 1'b0, i[2:0], 1'b0, i[2:0]});
      poll(`CGMC_OFS_CTRL_TWO, 32'hff, {24'h0, 1'b0, i[2:0], 1'b0, i[2:0]},
           "ctrl two");
      `CHECK("multiply", 5'(4 + 2 * i), multiplyFactor)
      `CHECK("divide", 8'(1 << i), divideFactor)
    end
    doReset();
    `CHECK("gain", 1'b0, highGain)
    slowStart <= 1'b1;
    wr(`CGMC_OFS_CTRL_TWO, 32'h00);
    wr(`CGMC_OFS_CTRL_ONE, 32'h38);
    poll(`CGMC_OFS_STAT_TWO, 32'h1, 32'h1, "stable");
    poll(`CGMC_OFS_STAT_ONE, 32'hc0, 32'hc0, "fee mode");
    `CHECK("osc request", 1'b1, oscRequest)
    `CHECK("low power", 1'b0, highGain)
    `CHECK("fee PN/R", 16'd256, 16'(prescaleFactor) * 16'(multiplyFactor)
           / 16'(divideFactor))
    lockEnable <= 1'b1;
    poll(`CGMC_OFS_STAT_ONE, 32'h08, 32'h08, "locked");
    lockEnable <= 1'b0;
    poll(`CGMC_OFS_STAT_ONE, 32'h05, 32'h05, "lock loss");
    wr(`CGMC_OFS_STAT_ONE, 32'hfe);
    `CHECK("irq kept", 1'b1, irqRequest)
    poll(`CGMC_OFS_STAT_ONE, 32'hc0, 32'hc0, "status ro");
    wr(`CGMC_OFS_STAT_ONE, 32'h01);
    `CHECK("irq clear", 1'b0, irqRequest)
    refPresent <= 1'b0;
    poll(`CGMC_OFS_STAT_ONE, 32'h11, 32'h11, "clock loss");
    poll(`CGMC_OFS_STAT_ONE, 32'hc0, 32'h00, "fall back");
    wr(`CGMC_OFS_STAT_ONE, 32'h01);
    refPresent <= 1'b1;
    wr(`CGMC_OFS_CTRL_TWO, 32'hb1);
    wr(`CGMC_OFS_CTRL_ONE, 32'h28);
    poll(`CGMC_OFS_STAT_ONE, 32'hc0, 32'h40, "fei mode");
    `CHECK("ref ignored", 1'b0, oscRequest)
    `CHECK("fei PN/R", 16'd320, 16'(prescaleFactor) * 16'(multiplyFactor)
           / 16'(divideFactor))
    wr(`CGMC_OFS_CTRL_TWO, 32'hb2);
    `CHECK("trim divide", 8'h04, divideFactor)
    wr(`CGMC_OFS_TRIM, 32'h5a);
    wr(`CGMC_OFS_CTRL_TWO, 32'hb1);
    `CHECK("divide back", 8'h02, divideFactor)
    `CHECK("trim out", 8'h5a, refTrim)
    prior = dcoFilter;
    wr(`CGMC_OFS_FILTER, 32'h0123);
    `CHECK("filter held", prior, dcoFilter)
    lockEnable <= 1'b1;
    poll(`CGMC_OFS_STAT_ONE, 32'h08, 32'h08, "locked");
    prev = resetSeen;
    lockEnable <= 1'b0;
    for (int n = 0; n < 40 && resetSeen == prev; n++) @(posedge clk_sys);
    `CHECK("loss reset", 1'b1, resetSeen > prev)
    `CHECK("no irq", 1'b0, irqRequest)
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results();
  end
endmodule
